// >>> hdl/keypad_pin_interrupt.sv
// Purpose: Keypad pin interrupt block with AXI4-Lite register access
// Assumes: Pins synchronous-safe via synchroniser, one clock aclk
// Notes: Break state and vector fetch arrive as plain inputs
//
// What this block does
// - Stays active in wait; wakes when unmasked
// - Stays active in stop; wakes when unmasked
// - Break-clear enable set lets acknowledge clear flag
// - Break-clear enable clear blocks acknowledge in break
// - Upper four status bits read zero
// - Pending flag read-only, shows latched request
// - Acknowledge write clears request, reads zero
// - Mask set blocks interrupt output
// - Sensitivity select: edge-and-level or edge only
// - Five pin enables admit pins to detection
// - Latch on new low after all high
// - Level mode clears after ack and pins high
// - Edge mode ack clears at once
// - Enabled pin gets pull-up, forced input
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module keypad_pin_interrupt (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] keypad_pin,
    input wire logic break_state,
    input wire logic vector_fetch,
    output logic [4:0] pullup_enable,
    output logic [4:0] force_input,
    output logic irq_out,
    output logic wake_request
);
    // ****************************************
    // Register state
    // ****************************************
    logic [4:0] pin_enable_reg;
    logic sensitivity_reg;
    logic mask_reg;
    logic break_clear_reg;
    logic [3:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic w_held_reg;
    logic w_strb0_reg;
    logic [4:0] pin_sync;
    logic request;

    // ****************************************
    // Write channel decode
    // ****************************************
    logic do_write;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    logic wr_status;
    logic wr_enable;
    logic wr_break;
    logic wr_mapped;
    logic ack_write;
    logic ack_allowed;
    logic ack_pulse;
    logic aw_take;
    logic w_take;
    logic aw_have;
    logic w_have;

    // Register map decode shared by both channels
    function automatic logic reg_mapped(input logic [3:0] addr);
        return (addr == keypad_pkg::STATUS_CONTROL_OFFSET) |
               (addr == keypad_pkg::PIN_ENABLE_OFFSET) |
               (addr == keypad_pkg::BREAK_CONTROL_OFFSET);
    endfunction

    // A channel item moves only on its own valid and ready
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign aw_have = aw_held_reg | aw_take;
    assign w_have = w_held_reg | w_take;

    // Address and data may arrive in either order
    assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    assign wr_lane0 = w_held_reg ? w_strb0_reg : s_axi_wstrb[0];
    assign do_write = aw_have & w_have & ~s_axi_bvalid;
    assign wr_status = do_write & wr_lane0 & (wr_addr == keypad_pkg::STATUS_CONTROL_OFFSET);
    assign wr_enable = do_write & wr_lane0 & (wr_addr == keypad_pkg::PIN_ENABLE_OFFSET);
    assign wr_break = do_write & wr_lane0 & (wr_addr == keypad_pkg::BREAK_CONTROL_OFFSET);
    assign wr_mapped = reg_mapped(wr_addr);

    // Acknowledge from software, gated in break, or from vector fetch
    assign ack_write = wr_status & wr_data[keypad_pkg::ACK_BIT];
    assign ack_allowed = ~break_state | break_clear_reg;
    assign ack_pulse = (ack_write & ack_allowed) | vector_fetch;

    // Hold address and data until the pair is complete
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h00000000;
            w_strb0_reg <= 1'b0;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
            end
            aw_held_reg <= do_write ? 1'b0 : aw_have;
            w_held_reg <= do_write ? 1'b0 : w_have;
        end
    end

    // Ready while nothing is held for that channel and no response waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_have & ~s_axi_bvalid;
            s_axi_wready <= ~w_have & ~s_axi_bvalid;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= keypad_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? keypad_pkg::RESP_OKAY : keypad_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_enable_reg <= keypad_pkg::PIN_ENABLE_RESET;
            sensitivity_reg <= keypad_pkg::SENSITIVITY_RESET;
            mask_reg <= keypad_pkg::MASK_RESET;
            break_clear_reg <= keypad_pkg::BREAK_CLEAR_RESET;
        end else begin
            if (wr_enable) begin
                pin_enable_reg <= wr_data[4:0];
            end
            if (wr_status) begin
                sensitivity_reg <= wr_data[keypad_pkg::SENSITIVITY_BIT];
                mask_reg <= wr_data[keypad_pkg::MASK_BIT];
            end
            if (wr_break) begin
                break_clear_reg <= wr_data[keypad_pkg::BREAK_CLEAR_BIT];
            end
        end
    end

    // ****************************************
    // Pin path and request latch
    // ****************************************
    keypad_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(keypad_pin),
        .pin_sync(pin_sync)
    );

    keypad_detect u_detect (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_sync(pin_sync),
        .pin_enable(pin_enable_reg),
        .sensitivity_select(sensitivity_reg),
        .ack_pulse(ack_pulse),
        .request(request)
    );

    // Outputs registered; no clock gating so wait and stop keep running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_out <= 1'b0;
            wake_request <= 1'b0;
            pullup_enable <= 5'h00;
            force_input <= 5'h00;
        end else begin
            irq_out <= request & ~mask_reg;
            wake_request <= request & ~mask_reg;
            pullup_enable <= pin_enable_reg;
            force_input <= pin_enable_reg;
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    logic [31:0] rd_value;
    logic rd_mapped;
    logic [7:0] status_read;

    // Upper bits zero, acknowledge reads zero
    assign status_read = {4'h0, request, 1'b0, mask_reg, sensitivity_reg};
    assign rd_mapped = reg_mapped(s_axi_araddr);
    assign rd_value = (s_axi_araddr == keypad_pkg::STATUS_CONTROL_OFFSET) ? {24'h0, status_read} :
                      (s_axi_araddr == keypad_pkg::PIN_ENABLE_OFFSET) ? {27'h0, pin_enable_reg} :
                      (s_axi_araddr == keypad_pkg::BREAK_CONTROL_OFFSET) ? {31'h0, break_clear_reg} :
                      32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= keypad_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_value;
                s_axi_rresp <= rd_mapped ? keypad_pkg::RESP_OKAY : keypad_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_break_protect: assert property (@(posedge aclk) disable iff (!aresetn)
        request && ack_write && break_state && !break_clear_reg && !vector_fetch |=> request)
        else $error("acknowledge cleared flag in protected break");

    a_irq_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 irq_out == ($past(request) && !$past(mask_reg)))
        else $error("interrupt output does not follow request and mask");

    a_masked_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        mask_reg && $past(mask_reg) |-> !irq_out)
        else $error("masked request raised interrupt");

    a_wake_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_request == irq_out)
        else $error("wake request differs from interrupt");

    a_status_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && $past(s_axi_araddr) == keypad_pkg::STATUS_CONTROL_OFFSET
        && $past(s_axi_arvalid && s_axi_arready) |-> s_axi_rdata[7:4] == 4'h0
        && s_axi_rdata[keypad_pkg::ACK_BIT] == 1'b0)
        else $error("status upper or acknowledge bit read nonzero");

    a_break_allow: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_write && break_state && break_clear_reg && !sensitivity_reg
        && !(|(~pin_sync & pin_enable_reg)) |=> !request)
        else $error("allowed break acknowledge did not clear");

    a_pullup_track: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 pullup_enable == $past(pin_enable_reg) && force_input == $past(pin_enable_reg))
        else $error("pull-up or input force does not track enable");

    // Any enabled pin low, for the checks below
    logic pin_low_any;
    assign pin_low_any = |(~pin_sync & pin_enable_reg);

    // Unmasked request raises the interrupt one cycle later
    a_irq_open: assert property (@(posedge aclk) disable iff (!aresetn)
        request && !mask_reg |=> irq_out)
        else $error("unmasked request gave no interrupt");

    // Unmasked request raises the wake request one cycle later
    a_wake_open: assert property (@(posedge aclk) disable iff (!aresetn)
        request && !mask_reg |=> wake_request)
        else $error("unmasked request gave no wake request");

    // Vector fetch in edge mode clears unless a new edge arrives
    a_vector_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        vector_fetch && !sensitivity_reg && !(pin_low_any && !$past(pin_low_any)) |=> !request)
        else $error("vector fetch did not clear edge request");

    // Pin enables change only on a write to their register
    a_enable_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_enable |=> $stable(pin_enable_reg))
        else $error("pin enables changed without a write");

    // Sensitivity and mask change only on a status write
    a_mode_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_status |=> $stable(sensitivity_reg) && $stable(mask_reg))
        else $error("sensitivity or mask changed without a write");
endmodule

// >>> hdl/keypad_pkg.sv
// Purpose: Shared constants for the keypad pin interrupt block
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes: Offsets and bit positions are used by the bus slave and the core
package keypad_pkg;
    localparam int PIN_COUNT = 5;
    localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] PIN_ENABLE_OFFSET = 4'h4;
    localparam logic [3:0] BREAK_CONTROL_OFFSET = 4'h8;
    localparam int SENSITIVITY_BIT = 0;
    localparam int MASK_BIT = 1;
    localparam int ACK_BIT = 2;
    localparam int PENDING_BIT = 3;
    localparam int BREAK_CLEAR_BIT = 0;
    localparam logic [4:0] PIN_ENABLE_RESET = 5'h00;
    localparam logic SENSITIVITY_RESET = 1'b0;
    localparam logic MASK_RESET = 1'b0;
    localparam logic BREAK_CLEAR_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/keypad_sync.sv
// Purpose: Two-stage synchroniser for the keypad pins
// Assumes: Pins idle high through their pull-ups
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module keypad_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_sync
);
    logic [4:0] stage1_reg;

    // Two flops per pin, reset to idle high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_reg <= 5'h1f;
            pin_sync <= 5'h1f;
        end else begin
            stage1_reg <= pin_in;
            pin_sync <= stage1_reg;
        end
    end
endmodule

// >>> hdl/keypad_detect.sv
// Purpose: Request latch with edge or edge-and-level sensitivity
// Assumes: Synchronised pins, acknowledge is a one-cycle pulse
// Notes: Disabled pins are treated as high
`timescale 1ns/1ns
module keypad_detect (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] pin_sync,
    input wire logic [4:0] pin_enable,
    input wire logic sensitivity_select,
    input wire logic ack_pulse,
    output logic request
);
    logic any_low;
    logic any_low_prev_reg;
    logic fall_event;
    logic request_next;
    logic ack_seen_reg;
    logic ack_seen_next;
    logic ack_any;

    // Any enabled pin low; new low only after all were high
    assign any_low = |(~pin_sync & pin_enable);
    assign fall_event = any_low & ~any_low_prev_reg;

    // Set wins over acknowledge; level mode holds while a pin is low
    assign ack_any = ack_pulse | ack_seen_reg;
    assign request_next = fall_event ? 1'b1 :
                          (ack_any & ~(sensitivity_select & any_low)) ? 1'b0 :
                          request;

    // Level mode keeps an early acknowledge until every pin is high
    assign ack_seen_next = ~fall_event & request_next & ack_any;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            any_low_prev_reg <= 1'b0;
            request <= 1'b0;
            ack_seen_reg <= 1'b0;
        end else begin
            any_low_prev_reg <= any_low;
            request <= request_next;
            ack_seen_reg <= ack_seen_next;
        end
    end

    // Edge mode: acknowledge clears at once unless an edge arrives
    a_edge_ack_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_pulse && !sensitivity_select && !fall_event |=> !request)
        else $error("edge mode acknowledge did not clear");

    // Level mode: request held while an enabled pin stays low
    a_level_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        request && sensitivity_select && any_low |=> request)
        else $error("level mode request dropped while pin low");

    // New low after all high latches a request
    a_fall_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(any_low) && any_low |=> request)
        else $error("falling edge did not latch");

    // No latch from a pin that is still low in edge mode
    a_no_spurious: assert property (@(posedge aclk) disable iff (!aresetn)
        !request && !fall_event |=> !request)
        else $error("request latched without a new edge");

    // Level mode: remembered acknowledge clears once all pins are high
    a_ack_remembered: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_seen_reg && !any_low |=> !request)
        else $error("remembered acknowledge did not clear");
endmodule

// >>> dv/keypad_switches.sv
// Purpose: Behavioural keypad switches on the five pins
// Assumes: A closed switch pulls its pin low
// Notes: An open pin with no pull-up wanders every cycle
`timescale 1ns/1ns
module keypad_switches (
    input wire logic aclk,
    input wire logic [4:0] press,
    input wire logic [4:0] pullup_enable,
    output logic [4:0] keypad_pin
);
    logic float_reg = 1'b0;
    // Wandering level for unpulled open pins
    always @(posedge aclk) begin
        float_reg <= ~float_reg;
    end
    // Closed switch wins, else pull-up, else wander
    assign keypad_pin = ~press & (pullup_enable | {5{float_reg}});
endmodule

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the keypad pin interrupt block
// Assumes: AXI4-Lite master, pins driven through the switch model
// Notes: Each scenario is its own task
`timescale 1ns/1ns
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [4:0] keypad_pin, pullup_enable, force_input, press = 5'h00;
    logic break_state = 1'b0, vector_fetch = 1'b0, irq_out, wake_request;
    int bad_count = 0;
    int compares = 0;
    logic [1:0] last_bresp = 2'h0;
    localparam logic [31:0] SENS = 32'h1, MASK = 32'h2, ACK = 32'h4, PEND = 32'h8;
    localparam logic [3:0] SC = keypad_pkg::STATUS_CONTROL_OFFSET;
    localparam logic [3:0] PE = keypad_pkg::PIN_ENABLE_OFFSET;
    localparam logic [3:0] BC = keypad_pkg::BREAK_CONTROL_OFFSET;

    always #20 aclk = ~aclk;

    keypad_pin_interrupt u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .keypad_pin(keypad_pin), .break_state(break_state),
        .vector_fetch(vector_fetch), .pullup_enable(pullup_enable),
        .force_input(force_input), .irq_out(irq_out), .wake_request(wake_request));
    keypad_switches u_sw (.aclk(aclk), .press(press), .pullup_enable(pullup_enable),
        .keypad_pin(keypad_pin));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic wrap_up();
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang();
        bad_count++;
        wrap_up();
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        last_bresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        if (n >= 100) hang();
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (n >= 100) hang();
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
        chk(32'(r), 32'(keypad_pkg::RESP_OKAY));
    endtask
    task automatic pins(input logic [4:0] p);
        press <= p;
        repeat (6) @(posedge aclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(SC, 32'h0);
        rd_chk(PE, 32'h0);
        rd_chk(BC, 32'h0);
        rd(4'hc, d, r);
        chk(32'(r), 32'(keypad_pkg::RESP_SLVERR));
        wr(4'hc, 32'h0);
        chk(32'(last_bresp), 32'(keypad_pkg::RESP_SLVERR));
        s_axi_wstrb <= 4'he;
        wr(SC, MASK);
        s_axi_wstrb <= 4'hf;
        rd_chk(SC, 32'h0);
        wr(SC, 32'hff);
        chk(32'(last_bresp), 32'(keypad_pkg::RESP_OKAY));
        rd_chk(SC, SENS | MASK);
        wr(SC, 32'h0);
    endtask
    task automatic t_edge();
        wr(PE, 32'h1f);
        chk(32'(pullup_enable), 32'h1f);
        chk(32'(force_input), 32'h1f);
        pins(5'h00);
        wr(SC, ACK);
        rd_chk(SC, 32'h0);
        pins(5'h01);
        rd_chk(SC, PEND);
        chk(32'({irq_out, wake_request}), 32'h3);
        wr(SC, ACK);
        rd_chk(SC, 32'h0);
        pins(5'h03);
        rd_chk(SC, 32'h0);
        pins(5'h00);
        pins(5'h04);
        rd_chk(SC, PEND);
        vector_fetch <= 1'b1;
        @(posedge aclk);
        vector_fetch <= 1'b0;
        repeat (3) @(posedge aclk);
        rd_chk(SC, 32'h0);
        pins(5'h00);
    endtask
    task automatic t_mask();
        wr(SC, MASK);
        pins(5'h08);
        rd_chk(SC, MASK | PEND);
        chk(32'({irq_out, wake_request}), 32'h0);
        wr(SC, ACK);
        pins(5'h00);
        rd_chk(SC, 32'h0);
    endtask
    task automatic t_level();
        wr(SC, SENS);
        pins(5'h10);
        wr(SC, SENS | ACK);
        rd_chk(SC, SENS | PEND);
        pins(5'h00);
        rd_chk(SC, SENS);
        pins(5'h02);
        pins(5'h00);
        rd_chk(SC, SENS | PEND);
        wr(SC, SENS | ACK);
        rd_chk(SC, SENS);
        wr(SC, 32'h0);
    endtask
    task automatic t_break();
        pins(5'h02);
        pins(5'h00);
        break_state <= 1'b1;
        wr(SC, ACK);
        rd_chk(SC, PEND);
        wr(BC, 32'h1);
        rd_chk(BC, 32'h1);
        wr(SC, ACK);
        break_state <= 1'b0;
        repeat (2) @(posedge aclk);
        rd_chk(SC, 32'h0);
        wr(BC, 32'h0);
    endtask
    task automatic t_disabled();
        wr(PE, 32'h0);
        chk(32'(pullup_enable), 32'h0);
        pins(5'h1f);
        rd_chk(SC, 32'h0);
        pins(5'h00);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_edge();
        t_mask();
        t_level();
        t_break();
        t_disabled();
        wrap_up();
    end
endmodule
